// *** rtl/aosc_pkg.sv ***
// constants, register map and reset values for the analog output scaling control
package aosc_pkg;

	localparam int          AOSC_NCH        = 8;

	// register byte addresses (10-bit address, word aligned)
	localparam logic [9:0]  AOSC_GCFG_ADDR  = 10'h000;
	localparam logic [9:0]  AOSC_STAT_ADDR  = 10'h004;
	localparam logic [9:0]  AOSC_DIAG_ADDR  = 10'h008;
	localparam logic [1:0]  AOSC_CH_PAGE    = 2'h1;
	localparam logic [2:0]  AOSC_CH_CTRL    = 3'h0;
	localparam logic [2:0]  AOSC_CH_SPLO    = 3'h1;
	localparam logic [2:0]  AOSC_CH_SPHI    = 3'h2;
	localparam logic [2:0]  AOSC_CH_ENLO    = 3'h3;
	localparam logic [2:0]  AOSC_CH_ENHI    = 3'h4;
	localparam logic [2:0]  AOSC_CH_OUT     = 3'h5;

	// global configuration fields and reset values
	localparam int          AOSC_AQLEN_LSB  = 0;
	localparam int          AOSC_DIBYT_LSB  = 4;
	localparam int          AOSC_DQBYT_LSB  = 6;
	localparam int          AOSC_HOLD_BIT   = 8;
	localparam logic [3:0]  AOSC_AQLEN_RST  = 4'h8;
	localparam logic [1:0]  AOSC_DIBYT_RST  = 2'h3;
	localparam logic [1:0]  AOSC_DQBYT_RST  = 2'h2;
	localparam logic        AOSC_HOLD_RST   = 1'b0;

	// channel control fields
	localparam int          AOSC_ACT_BIT    = 0;
	localparam int          AOSC_UNI_BIT    = 1;

	// scaling presets and limits in millivolts / units
	localparam logic signed [15:0] AOSC_BIP_LO = -16'sd10000;
	localparam logic signed [15:0] AOSC_BIP_HI = 16'sd10000;
	localparam logic signed [15:0] AOSC_UNI_LO = 16'sd0;
	localparam logic signed [15:0] AOSC_UNI_HI = 16'sd10000;
	localparam logic signed [15:0] AOSC_SPAN_MIN = -16'sd16384;
	localparam logic signed [15:0] AOSC_SPAN_MAX = 16'sd16383;
	localparam logic signed [15:0] AOSC_HW_MAX   = 16'sd10250;
	localparam logic signed [15:0] AOSC_ALM_MARGIN = 16'sd50;

	// divider iterations over the product magnitude
	localparam logic [5:0]  AOSC_DIV_STEPS  = 6'd34;

	typedef enum logic [1:0] {
		AOSC_S_IDLE = 2'b00,
		AOSC_S_DIV  = 2'b01,
		AOSC_S_DONE = 2'b10
	} aosc_state_t;

endpackage

// *** rtl/aosc_ctrl.sv ***
// eight-channel analog output scaling, channel enable and output default control
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module aosc_ctrl (
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire logic [9:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	input  wire logic                 out_word_wr,
	input  wire logic [2:0]           out_word_idx,
	input  wire logic [15:0]          out_word,
	input  wire logic                 fclr_wr,
	input  wire logic [15:0]          fclr_bits,
	input  wire logic                 host_rst_pin,
	input  wire logic                 host_tmo_pin,
	input  wire logic                 bp_lost_pin,
	input  wire logic                 wdog_pin,
	input  wire logic                 user_pwr_pin,
	output logic [aosc_pkg::AOSC_NCH-1:0][15:0] dac_mv,
	output logic                      dac_load,
	output logic      [23:0]          diag_bits
);
	import aosc_pkg::*;

	logic        [3:0]  aq_len_ff;
	logic        [1:0]  di_byt_ff;
	logic        [1:0]  dq_byt_ff;
	logic               hold_ff;
	logic        [7:0]  act_ff;
	logic        [7:0]  uni_ff;
	logic signed [15:0] splo_ff [AOSC_NCH];
	logic signed [15:0] sphi_ff [AOSC_NCH];
	logic signed [15:0] enlo_ff [AOSC_NCH];
	logic signed [15:0] enhi_ff [AOSC_NCH];
	logic signed [15:0] cmd_ff  [AOSC_NCH];
	logic        [7:0]  pend_ff;
	logic        [7:0]  over_ff;
	logic        [7:0]  under_ff;
	logic               pwr_alm_ff;
	logic               held_ff;
	logic        [4:0]  s1_ff, s2_ff, s3_ff, filt_ff, filt_d_ff;
	aosc_state_t        state_ff;
	logic        [2:0]  cur_ff;
	logic        [33:0] quo_ff;
	logic        [17:0] rem_ff;
	logic        [16:0] den_ff;
	logic               neg_ff;
	logic        [5:0]  cnt_ff;

	// ---------- pin synchronisers ----------
	logic [4:0] pins;
	assign pins = {user_pwr_pin, wdog_pin, bp_lost_pin, host_tmo_pin, host_rst_pin};

	// a level counts only once second and third stages agree
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s1_ff     <= 5'h00;
			s2_ff     <= 5'h00;
			s3_ff     <= 5'h00;
			filt_ff   <= 5'h00;
			filt_d_ff <= 5'h00;
		end else begin
			s1_ff     <= pins;
			s2_ff     <= s1_ff;
			s3_ff     <= s2_ff;
			filt_ff   <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
			filt_d_ff <= filt_ff;
		end
	end

	logic user_pwr, pwr_fall, fail_evt;
	assign user_pwr = filt_ff[4];
	assign pwr_fall = filt_d_ff[4] & ~filt_ff[4];
	assign fail_evt = |(filt_ff[3:0] & ~filt_d_ff[3:0]);

	// ---------- register decode ----------
	logic       ch_sel;
	logic [2:0] ch_a;
	logic [2:0] ch_r;
	assign ch_sel = (reg_addr[9:8] == AOSC_CH_PAGE) && (reg_addr[1:0] == 2'h0);
	assign ch_a   = reg_addr[7:5];
	assign ch_r   = reg_addr[4:2];

	// defaults at reset; global configuration write
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			aq_len_ff <= AOSC_AQLEN_RST;
			di_byt_ff <= AOSC_DIBYT_RST;
			dq_byt_ff <= AOSC_DQBYT_RST;
			hold_ff   <= AOSC_HOLD_RST;
		end else if (reg_wr && reg_addr == AOSC_GCFG_ADDR) begin
			aq_len_ff <= (reg_wdata[AOSC_AQLEN_LSB+:4] > AOSC_AQLEN_RST) ? AOSC_AQLEN_RST
			             : reg_wdata[AOSC_AQLEN_LSB+:4];
			di_byt_ff <= reg_wdata[AOSC_DIBYT_LSB+:2];
			// only 0, 8 or 16 bits exist
			dq_byt_ff <= (reg_wdata[AOSC_DQBYT_LSB+:2] > AOSC_DQBYT_RST) ? AOSC_DQBYT_RST
			             : reg_wdata[AOSC_DQBYT_LSB+:2];
			hold_ff   <= reg_wdata[AOSC_HOLD_BIT];
		end
	end

	function automatic logic signed [15:0] span_clip(input logic [31:0] w);
		logic signed [15:0] v;
		v = w[15:0];
		if (v < AOSC_SPAN_MIN)
			span_clip = AOSC_SPAN_MIN;
		else if (v > AOSC_SPAN_MAX)
			span_clip = AOSC_SPAN_MAX;
		else
			span_clip = v;
	endfunction

	// per-channel configuration; picking a range reloads its preset points
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			act_ff <= 8'hff;
			uni_ff <= 8'h00;
			for (int i = 0; i < AOSC_NCH; i++) begin
				splo_ff[i] <= AOSC_BIP_LO;
				sphi_ff[i] <= AOSC_BIP_HI;
				enlo_ff[i] <= AOSC_BIP_LO;
				enhi_ff[i] <= AOSC_BIP_HI;
			end
		end else if (reg_wr && ch_sel) begin
			case (ch_r)
				AOSC_CH_CTRL: begin
					act_ff[ch_a] <= reg_wdata[AOSC_ACT_BIT];
					uni_ff[ch_a] <= reg_wdata[AOSC_UNI_BIT];
					splo_ff[ch_a] <= reg_wdata[AOSC_UNI_BIT] ? AOSC_UNI_LO : AOSC_BIP_LO;
					sphi_ff[ch_a] <= reg_wdata[AOSC_UNI_BIT] ? AOSC_UNI_HI : AOSC_BIP_HI;
					enlo_ff[ch_a] <= reg_wdata[AOSC_UNI_BIT] ? AOSC_UNI_LO : AOSC_BIP_LO;
					enhi_ff[ch_a] <= reg_wdata[AOSC_UNI_BIT] ? AOSC_UNI_HI : AOSC_BIP_HI;
				end
				AOSC_CH_SPLO: splo_ff[ch_a] <= span_clip(reg_wdata);
				AOSC_CH_SPHI: sphi_ff[ch_a] <= span_clip(reg_wdata);
				AOSC_CH_ENLO: enlo_ff[ch_a] <= reg_wdata[15:0];
				AOSC_CH_ENHI: enhi_ff[ch_a] <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// readback, present only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0;
		end else if (reg_addr == AOSC_GCFG_ADDR) begin
			reg_rdata <= {23'h0, hold_ff, dq_byt_ff, di_byt_ff, aq_len_ff};
		end else if (reg_addr == AOSC_STAT_ADDR) begin
			reg_rdata <= {16'h0, pend_ff, 5'h0, (state_ff != AOSC_S_IDLE), user_pwr, held_ff};
		end else if (reg_addr == AOSC_DIAG_ADDR) begin
			reg_rdata <= {8'h0, 7'h0, pwr_alm_ff, under_ff, over_ff};
		end else if (ch_sel) begin
			case (ch_r)
				AOSC_CH_CTRL: reg_rdata <= {30'h0, uni_ff[ch_a], act_ff[ch_a]};
				AOSC_CH_SPLO: reg_rdata <= {{16{splo_ff[ch_a][15]}}, splo_ff[ch_a]};
				AOSC_CH_SPHI: reg_rdata <= {{16{sphi_ff[ch_a][15]}}, sphi_ff[ch_a]};
				AOSC_CH_ENLO: reg_rdata <= {{16{enlo_ff[ch_a][15]}}, enlo_ff[ch_a]};
				AOSC_CH_ENHI: reg_rdata <= {{16{enhi_ff[ch_a][15]}}, enhi_ff[ch_a]};
				AOSC_CH_OUT:  reg_rdata <= {{16{dac_mv[ch_a][15]}}, dac_mv[ch_a]};
				default:      reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// ---------- host output words ----------
	logic word_ok;
	// words beyond length or for inactive channels are dropped
	assign word_ok = out_word_wr && ({1'b0, out_word_idx} < aq_len_ff) && act_ff[out_word_idx];

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int i = 0; i < AOSC_NCH; i++)
				cmd_ff[i] <= 16'sh0;
		end else if (word_ok) begin
			cmd_ff[out_word_idx] <= out_word;
		end
	end

	logic [2:0] pick;
	always_comb begin
		pick = 3'h0;
		for (int i = AOSC_NCH - 1; i >= 0; i--)
			if (pend_ff[i])
				pick = 3'(i);
	end

	logic take;
	assign take = (state_ff == AOSC_S_IDLE) && (|pend_ff);

	// a fresh word in the cycle its channel is taken stays pending
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pend_ff <= 8'h00;
		end else begin
			for (int i = 0; i < AOSC_NCH; i++)
				if (word_ok && out_word_idx == 3'(i))
					pend_ff[i] <= 1'b1;
				else if ((take && pick == 3'(i)) || !act_ff[i])
					pend_ff[i] <= 1'b0;
		end
	end

	// ---------- scaling datapath ----------
	// 17-bit differences, 34-bit product, restoring divide
	logic signed [16:0] d_eng, d_spn, d_cmd;
	logic signed [33:0] prod;
	assign d_eng = 17'(enhi_ff[pick]) - 17'(enlo_ff[pick]);
	assign d_spn = 17'(sphi_ff[pick]) - 17'(splo_ff[pick]);
	assign d_cmd = 17'(cmd_ff[pick]) - 17'(enlo_ff[pick]);
	assign prod  = 34'(d_cmd) * 34'(d_spn);

	logic [17:0] rem_sh;
	assign rem_sh = {rem_ff[16:0], quo_ff[33]};

	logic        [34:0] q_rnd;
	logic signed [35:0] q_sgn, sum;
	logic signed [15:0] res;
	always_comb begin
		q_rnd = {1'b0, quo_ff} + 35'({rem_ff[16:0], 1'b0} >= {1'b0, den_ff});
		q_sgn = neg_ff ? -36'(q_rnd) : 36'(q_rnd);
		// straight line through both points; zero spread keeps low span
		sum   = (den_ff == 17'h0) ? 36'(splo_ff[cur_ff]) : 36'(splo_ff[cur_ff]) + q_sgn;
		// only the hardware limit bounds the result
		if (sum > 36'(AOSC_HW_MAX))
			res = AOSC_HW_MAX;
		else if (sum < -36'(AOSC_HW_MAX))
			res = -AOSC_HW_MAX;
		else
			res = sum[15:0];
	end

	// points are sampled when a channel's update starts; the low span point is read again when it finishes
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_ff <= AOSC_S_IDLE;
			cur_ff   <= 3'h0;
			quo_ff   <= 34'h0;
			rem_ff   <= 18'h0;
			den_ff   <= 17'h0;
			neg_ff   <= 1'b0;
			cnt_ff   <= 6'h0;
		end else begin
			case (state_ff)
				AOSC_S_IDLE: if (take) begin
					cur_ff   <= pick;
					quo_ff   <= prod[33] ? 34'(-prod) : 34'(prod);
					den_ff   <= d_eng[16] ? 17'(-d_eng) : 17'(d_eng);
					neg_ff   <= prod[33] ^ d_eng[16];
					rem_ff   <= 18'h0;
					cnt_ff   <= 6'h0;
					state_ff <= AOSC_S_DIV;
				end
				AOSC_S_DIV: begin
					if (rem_sh >= {1'b0, den_ff}) begin
						rem_ff <= rem_sh - {1'b0, den_ff};
						quo_ff <= {quo_ff[32:0], 1'b1};
					end else begin
						rem_ff <= rem_sh;
						quo_ff <= {quo_ff[32:0], 1'b0};
					end
					cnt_ff <= cnt_ff + 6'h1;
					if (cnt_ff == AOSC_DIV_STEPS - 6'h1)
						state_ff <= AOSC_S_DONE;
				end
				AOSC_S_DONE: state_ff <= AOSC_S_IDLE;
				default:     state_ff <= AOSC_S_IDLE;
			endcase
		end
	end

	logic done;
	assign done = (state_ff == AOSC_S_DONE) && act_ff[cur_ff];

	// ---------- outputs and output defaults ----------
	logic zero_all, hold_now;
	// hold only with hold selected and user power present
	assign hold_now = hold_ff && user_pwr;
	// failure without hold zeroes; power loss ends a hold
	assign zero_all = (fail_evt && !hold_now) || (pwr_fall && held_ff);

	// inactive channel still showing a value: it drops to zero this edge
	logic [7:0] kill;
	always_comb begin
		kill = 8'h00;
		for (int i = 0; i < AOSC_NCH; i++)
			kill[i] = !act_ff[i] && (dac_mv[i] != 16'h0);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dac_mv   <= '0;
			dac_load <= 1'b0;
		end else begin
			// load marks the very edge an output moves, so the converter never misses one
			dac_load <= done || zero_all || (|kill);
			for (int i = 0; i < AOSC_NCH; i++)
				// inactive channel forced to 0 V
				if (zero_all || !act_ff[i])
					dac_mv[i] <= 16'h0;
				else if (done && cur_ff == 3'(i))
					dac_mv[i] <= res;
		end
	end

	// hold flag ends on new data or loss of user power
	always_ff @(posedge core_clk) begin
		if (!rstn)
			held_ff <= 1'b0;
		else if (fail_evt && hold_now)
			held_ff <= 1'b1;
		else if (word_ok || !user_pwr)
			held_ff <= 1'b0;
	end

	// ---------- alarms and fault clearing ----------
	logic [7:0] clr_ch;
	logic       clr_pwr;
	logic       hit_over, hit_under;
	// clear bits honoured only inside configured length
	assign clr_ch  = (fclr_wr && dq_byt_ff >= 2'h1) ? fclr_bits[7:0] : 8'h00;
	assign clr_pwr = fclr_wr && (dq_byt_ff >= 2'h2) && fclr_bits[8];
	// within 50 mV of either extreme
	assign hit_over  = res >= (AOSC_HW_MAX - AOSC_ALM_MARGIN);
	assign hit_under = res <= (AOSC_ALM_MARGIN - AOSC_HW_MAX);

	// setting wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			over_ff    <= 8'h00;
			under_ff   <= 8'h00;
			pwr_alm_ff <= 1'b0;
		end else begin
			for (int i = 0; i < AOSC_NCH; i++) begin
				// inactive channels never set, but still clear
				if (done && cur_ff == 3'(i) && hit_over)
					over_ff[i] <= 1'b1;
				else if (clr_ch[i])
					over_ff[i] <= 1'b0;
				if (done && cur_ff == 3'(i) && hit_under)
					under_ff[i] <= 1'b1;
				else if (clr_ch[i])
					under_ff[i] <= 1'b0;
			end
			if (!user_pwr)
				pwr_alm_ff <= 1'b1;
			else if (clr_pwr)
				pwr_alm_ff <= 1'b0;
		end
	end

	// bytes beyond the configured length read as zero
	always_ff @(posedge core_clk) begin
		if (!rstn)
			diag_bits <= 24'h0;
		else
			diag_bits <= {7'h0, pwr_alm_ff, under_ff, over_ff}
			             & {{8{di_byt_ff >= 2'h3}}, {8{di_byt_ff >= 2'h2}}, {8{di_byt_ff >= 2'h1}}};
	end

endmodule
`default_nettype wire

// *** test/aosc_ctrl_sva.sv ***
// port-level assertions for the analog output scaling control
`timescale 1ns/1ns
`default_nettype none
module aosc_ctrl_sva (
	input wire logic                                core_clk,
	input wire logic                                rstn,
	input wire logic [9:0]                          reg_addr,
	input wire logic                                reg_rd,
	input wire logic [31:0]                         reg_rdata,
	input wire logic                                fclr_wr,
	input wire logic [15:0]                         fclr_bits,
	input wire logic [aosc_pkg::AOSC_NCH-1:0][15:0] dac_mv,
	input wire logic                                dac_load,
	input wire logic [23:0]                         diag_bits
);
	import aosc_pkg::*;
	logic over_rng;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	always_comb begin
		over_rng = 1'b0;
		for (int i = 0; i < AOSC_NCH; i++) begin
			if ($signed(dac_mv[i]) > AOSC_HW_MAX || $signed(dac_mv[i]) < -AOSC_HW_MAX) begin
				over_rng = 1'b1;
			end
		end
	end
	sequence s_over;
		dac_load && $signed(dac_mv[0]) >= AOSC_HW_MAX - AOSC_ALM_MARGIN;
	endsequence
	sequence s_under;
		dac_load && $signed(dac_mv[0]) <= AOSC_ALM_MARGIN - AOSC_HW_MAX;
	endsequence
	// no load in the clear cycle or the next, else a set in the clear cycle would win
	sequence s_clr;
		fclr_wr && fclr_bits[0] && !dac_load ##1 !dac_load;
	endsequence
	property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	property p_unmap; reg_rd && reg_addr == 10'h3fc |=> reg_rdata == 32'h0; endproperty
	property p_rst_zero; $rose(rstn) |-> dac_mv == '0 && !dac_load && diag_bits == 24'h0; endproperty
	property p_quiet; !$stable(dac_mv) |-> dac_load; endproperty
	property p_hw_lim; !over_rng; endproperty
	property p_diag_top; diag_bits[23:17] == 7'h0; endproperty
	property p_over; s_over |-> ##[1:2] diag_bits[0]; endproperty
	property p_under; s_under |-> ##[1:2] diag_bits[8]; endproperty
	property p_fclr; s_clr |-> ##1 !diag_bits[0]; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero after reset");
	a_quiet: assert property (p_quiet) else $error("output moved without load");
	a_hw_lim: assert property (p_hw_lim) else $error("output beyond hardware limit");
	a_diag_top: assert property (p_diag_top) else $error("unused diag bits set");
	a_over: assert property (p_over) else $error("overrange alarm missing");
	a_under: assert property (p_under) else $error("underrange alarm missing");
	a_fclr: assert property (p_fclr) else $error("alarm not cleared");
endmodule
bind aosc_ctrl aosc_ctrl_sva u_sva (.core_clk, .rstn, .reg_addr, .reg_rd, .reg_rdata, .fclr_wr,
	.fclr_bits, .dac_mv, .dac_load, .diag_bits);
`default_nettype wire

// *** test/aosc_host_model.sv ***
// bus host unit stand-in: output words, fault-clear bits, event and power pins
`timescale 1ns/1ns
`default_nettype none
module aosc_host_model #(
	parameter int AQ_REF = 0
) (
	input  wire logic  core_clk,
	input  wire logic [23:0] diag_bits,
	output logic       out_word_wr,
	output logic [2:0] out_word_idx,
	output logic [15:0] out_word,
	output logic       fclr_wr,
	output logic [15:0] fclr_bits,
	output wire logic  host_rst_pin,
	output wire logic  host_tmo_pin,
	output wire logic  bp_lost_pin,
	output wire logic  wdog_pin,
	output logic       user_pwr_pin
);
	logic [3:0] ev;
	// host image of the module's diagnostic bytes
	logic [23:0] di_img;
	logic        link_up;
	logic        di_hold;
	always @(posedge core_clk) begin
		if (link_up)
			di_img <= diag_bits;
		else if (!di_hold)
			di_img <= 24'h0;
	end
	assign {wdog_pin, bp_lost_pin, host_tmo_pin, host_rst_pin} = ev;
	initial begin
		ev = 4'h0;
		out_word_wr = 1'b0;
		out_word_idx = 3'h0;
		out_word = 16'h0;
		fclr_wr = 1'b0;
		fclr_bits = 16'h0;
		user_pwr_pin = 1'b1;
		link_up = 1'b1;
		di_hold = 1'b0;
	end
	// lost module link: zero the image unless holding
	task automatic lose_link(input logic hold);
		@(posedge core_clk);
		di_hold <= hold;
		link_up <= 1'b0;
	endtask
	task automatic send_word(input int slot, input logic [15:0] w);
		@(posedge core_clk);
		out_word_wr <= 1'b1;
		out_word_idx <= 3'(slot - AQ_REF);
		out_word <= w;
		@(posedge core_clk);
		out_word_wr <= 1'b0;
		out_word_idx <= ~out_word_idx;
		out_word <= ~w;
	endtask
	task automatic send_fclr(input logic [15:0] b);
		@(posedge core_clk);
		fclr_wr <= 1'b1;
		fclr_bits <= b;
		@(posedge core_clk);
		fclr_wr <= 1'b0;
		fclr_bits <= ~b;
	endtask
	// lost network: zero output words and clear bits unless holding
	task automatic lose_net(input logic hold);
		if (!hold) begin
			for (int i = 0; i < 8; i++)
				send_word(i + AQ_REF, 16'h0);
			send_fclr(16'h0);
		end
	endtask
	// k: 0 host reset, 1 timeout, 2 backplane loss, 3 watchdog
	task automatic pulse(input int k);
		@(posedge core_clk);
		ev <= 4'h1 << k;
		repeat (3) @(posedge core_clk);
		ev <= 4'h0;
	endtask
	task automatic set_pwr(input logic p);
		@(posedge core_clk);
		user_pwr_pin <= p;
	endtask
endmodule
`default_nettype wire

// *** test/test_aosc_ctrl.sv ***
// self-checking bench for the analog output scaling control
`timescale 1ns/1ns
`default_nettype none
module test_aosc_ctrl;
	import aosc_pkg::*;
	logic                      core_clk;
	logic                      rstn;
	logic [9:0]                reg_addr;
	logic [31:0]               reg_wdata;
	logic                      reg_wr;
	logic                      reg_rd;
	logic [31:0]               reg_rdata;
	logic                      out_word_wr;
	logic [2:0]                out_word_idx;
	logic [15:0]               out_word;
	logic                      fclr_wr;
	logic [15:0]               fclr_bits;
	logic                      host_rst_pin;
	logic                      host_tmo_pin;
	logic                      bp_lost_pin;
	logic                      wdog_pin;
	logic                      user_pwr_pin;
	logic [AOSC_NCH-1:0][15:0] dac_mv;
	logic                      dac_load;
	logic [23:0]               diag_bits;
	int                        n_errors;
	int                        checks_done;
	int                        cyc;
	aosc_ctrl uut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .out_word_wr,
		.out_word_idx, .out_word, .fclr_wr, .fclr_bits, .host_rst_pin, .host_tmo_pin, .bp_lost_pin,
		.wdog_pin, .user_pwr_pin, .dac_mv, .dac_load, .diag_bits);
	aosc_host_model host (.core_clk, .diag_bits, .out_word_wr, .out_word_idx, .out_word, .fclr_wr, .fclr_bits,
		.host_rst_pin, .host_tmo_pin, .bp_lost_pin, .wdog_pin, .user_pwr_pin);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic close_out();
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// run is about 1200 cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
	function automatic logic [9:0] ca(input int ch, input logic [2:0] off);
		return {AOSC_CH_PAGE, 3'(ch), off, 2'b00};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one word, then wait for its load and compare the channel
	task automatic scl(input int i, input logic [15:0] c, input logic [15:0] e);
		bit got;
		got = 1'b0;
		host.send_word(i, c);
		repeat (100) begin
			@(posedge core_clk);
			#1;
			if (dac_load === 1'b1) begin
				got = 1'b1;
				break;
			end
		end
		chk("dac_load", 32'h1, {31'h0, got});
		chk("dac_mv", {16'h0, e}, {16'h0, dac_mv[i]});
	endtask
	initial begin
		rstn = 1'b0;
		reg_addr = 10'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_errors = 0;
		checks_done = 0;
		cyc = 0;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (5) @(posedge core_clk);
		host.send_fclr(16'h0100);
		rd(AOSC_GCFG_ADDR, 32'h0b8);
		rd(ca(0, AOSC_CH_CTRL), 32'h1);
		rd(ca(0, AOSC_CH_SPLO), 32'hffff_d8f0);
		rd(ca(7, AOSC_CH_ENHI), 32'h2710);
		rd(10'h3fc, 32'h0);
		wr(ca(0, AOSC_CH_SPLO), 32'hffff_b1e0);
		rd(ca(0, AOSC_CH_SPLO), 32'hffff_c000);
		wr(ca(0, AOSC_CH_SPLO), 32'hffff_d8f0);
		scl(0, 16'h1388, 16'h1388);
		scl(0, 16'h27d8, 16'h27d8);
		wait_n(1);
		chk("over", 32'h1, {31'h0, diag_bits[0]});
		scl(0, 16'hd7c4, 16'hd7f6);
		wait_n(2);
		chk("under", 32'h1, {31'h0, diag_bits[8]});
		host.lose_link(1'b1);
		wait_n(2);
		chk("di_img", 32'h101, {8'h0, host.di_img});
		host.lose_link(1'b0);
		wait_n(2);
		chk("di_img", 32'h0, {8'h0, host.di_img});
		wr(AOSC_GCFG_ADDR, 32'h098);
		wait_n(2);
		chk("diag", 32'h1, {8'h0, diag_bits});
		wr(AOSC_GCFG_ADDR, 32'h0ff);
		rd(AOSC_GCFG_ADDR, 32'h0b8);
		scl(0, 16'h0, 16'h0);
		host.send_fclr(16'h0001);
		wait_n(3);
		chk("diag", 32'h0, {8'h0, diag_bits});
		wr(ca(1, AOSC_CH_SPLO), 32'h0);
		wr(ca(1, AOSC_CH_SPHI), 32'h2710);
		scl(1, 16'h0001, 16'h1389);
		scl(1, 16'hd8ef, 16'hffff);
		wr(ca(3, AOSC_CH_CTRL), 32'h3);
		rd(ca(3, AOSC_CH_SPLO), 32'h0);
		rd(ca(3, AOSC_CH_ENLO), 32'h0);
		scl(3, 16'hfe0c, 16'hfe0c);
		scl(4, 16'h27d8, 16'h27d8);
		wr(ca(4, AOSC_CH_CTRL), 32'h0);
		wait_n(2);
		chk("dac4", 32'h0, {16'h0, dac_mv[4]});
		chk("over4", 32'h1, {31'h0, diag_bits[4]});
		host.send_fclr(16'h0010);
		wait_n(3);
		chk("over4", 32'h0, {31'h0, diag_bits[4]});
		wr(ca(2, AOSC_CH_CTRL), 32'h0);
		host.send_word(2, 16'h1388);
		wait_n(60);
		chk("dac2", 32'h0, {16'h0, dac_mv[2]});
		chk("dac1", 32'hffff, {16'h0, dac_mv[1]});
		wr(AOSC_GCFG_ADDR, 32'h0b2);
		host.send_word(3, 16'h0);
		wait_n(60);
		chk("dac3", 32'hfe0c, {16'h0, dac_mv[3]});
		wr(AOSC_GCFG_ADDR, 32'h0b8);
		host.lose_net(1'b1);
		wait_n(2);
		chk("dac3", 32'hfe0c, {16'h0, dac_mv[3]});
		host.lose_net(1'b0);
		wait_n(300);
		chk("dac3", 32'h0, {16'h0, dac_mv[3]});
		chk("dac0", 32'h0, {16'h0, dac_mv[0]});
		scl(0, 16'h1388, 16'h1388);
		host.pulse(0);
		wait_n(12);
		chk("dac0", 32'h0, {16'h0, dac_mv[0]});
		chk("dac1", 32'h0, {16'h0, dac_mv[1]});
		wr(AOSC_GCFG_ADDR, 32'h1b8);
		for (int k = 0; k < 4; k++) begin
			scl(0, 16'h1388, 16'h1388);
			host.pulse(k);
			wait_n(12);
			chk("held", 32'h1388, {16'h0, dac_mv[0]});
			rd(AOSC_STAT_ADDR, 32'h3);
		end
		scl(0, 16'h07d0, 16'h07d0);
		rd(AOSC_STAT_ADDR, 32'h2);
		host.pulse(2);
		wait_n(12);
		host.set_pwr(1'b0);
		wait_n(12);
		chk("dac0", 32'h0, {16'h0, dac_mv[0]});
		host.set_pwr(1'b1);
		wait_n(8);
		wr(AOSC_GCFG_ADDR, 32'h078);
		host.send_fclr(16'h0100);
		wait_n(3);
		chk("pwr_alm", 32'h1, {31'h0, diag_bits[16]});
		wr(AOSC_GCFG_ADDR, 32'h0b8);
		host.send_fclr(16'h0100);
		wait_n(3);
		chk("pwr_alm", 32'h0, {31'h0, diag_bits[16]});
		close_out();
	end
endmodule
`default_nettype wire
